/* verilog/dssc_device.sv */
// Purpose: Serial-programmed latches, dividers, phase detectors, probe mux
// Assumes: ref_clk is the reference input; vco ticks are one-cycle pulses
// Notes: Link pins pass two flip-flops before use
module dssc_pfd
  import dssc_pkg::*;
#(
  parameter int ABL = ABL_CYC,
  parameter int WIN = LOCK_WIN_CYC,
  parameter int LOCKN = LOCK_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ref_pulse,
  input wire logic fb_pulse,
  input wire logic off,
  output logic pump_up,
  output logic pump_dn,
  output logic dlock,
  output logic alock
);
  logic up_q;
  logic dn_q;
  logic [3:0] abl_cnt;
  logic [7:0] err_cnt;
  logic [3:0] lock_cnt;
  logic both;

  assign both = up_q & dn_q;

  // ----------------------------------------
  // Phase-frequency state with anti-backlash
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      abl_cnt <= 4'h0;
    end else if (both && abl_cnt >= 4'(ABL - 1)) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      abl_cnt <= 4'h0;
    end else begin
      up_q <= up_q | ref_pulse;
      dn_q <= dn_q | fb_pulse;
      abl_cnt <= both ? abl_cnt + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------
  // Error width and lock counting
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_cnt <= 8'h00;
      lock_cnt <= 4'h0;
    end else if (both && abl_cnt >= 4'(ABL - 1)) begin
      err_cnt <= 8'h00;
      if (err_cnt > 8'(WIN)) begin
        lock_cnt <= 4'h0;
      end else if (lock_cnt < 4'(LOCKN)) begin
        lock_cnt <= lock_cnt + 4'h1;
      end
    end else if ((up_q ^ dn_q) && err_cnt != 8'hFF) begin
      err_cnt <= err_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
      dlock <= 1'b0;
      alock <= 1'b1;
    end else begin
      pump_up <= up_q & ~off;
      pump_dn <= dn_q & ~off;
      dlock <= (lock_cnt == 4'(LOCKN));
      alock <= ~(up_q ^ dn_q);
    end
  end
endmodule

module dssc_device
  import dssc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  dssc_if.device link,
  input wire logic rf_vco_tick,
  input wire logic if_vco_tick,
  output logic rf_pump_up,
  output logic rf_pump_dn,
  output logic if_pump_up,
  output logic if_pump_dn
);
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic sclk_rise;
  logic strobe_rise;
  logic [SR_W-1:0] shift_reg;
  logic [RF_N_W-1:0] rf_feedback_divider;
  logic [RF_R_W-1:0] rf_reference_divider;
  logic [RF_CTL_W-1:0] rf_loop_control;
  logic [MASTER_W-1:0] global_control;
  logic [IF_N_W-1:0] if_feedback_divider;
  logic [IF_R_W-1:0] if_reference_divider;
  logic [IF_CTL_W-1:0] if_loop_control;

  // ----------------------------------------
  // Link synchronisers and shift register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    sync1 <= {link.ser_clk, link.ser_data, link.latch_strobe};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  assign sclk_rise = sync2[2] & ~sync3[2];
  assign strobe_rise = sync2[0] & ~sync3[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[SR_W-2:0], sync2[1]};
    end
  end

  // ----------------------------------------
  // Destination latches
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rf_feedback_divider <= '0;
      rf_reference_divider <= '0;
      rf_loop_control <= '0;
      global_control <= '0;
      if_feedback_divider <= '0;
      if_reference_divider <= '0;
      if_loop_control <= '0;
    end else if (strobe_rise) begin
      unique case (shift_reg[2:0])
        ADDR_RF_N: rf_feedback_divider <= shift_reg[RF_N_W-1:0];
        ADDR_RF_R: rf_reference_divider <= shift_reg[RF_R_W-1:0];
        ADDR_RF_CTL: rf_loop_control <= shift_reg[RF_CTL_W-1:0];
        ADDR_MASTER: global_control <= shift_reg[MASTER_W-1:0];
        ADDR_IF_N: if_feedback_divider <= shift_reg[IF_N_W-1:0];
        ADDR_IF_R: if_reference_divider <= shift_reg[IF_R_W-1:0];
        ADDR_IF_CTL: if_loop_control <= shift_reg[IF_CTL_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic [INT_W-1:0] rf_int;
  logic [FRAC_W-1:0] rf_frac;
  logic [FRAC_W-1:0] rf_den;
  logic [RFR_W-1:0] rf_r;
  logic rf_dbl;
  logic [IFR_W-1:0] if_r;
  logic [A_W-1:0] if_a;
  logic [B_W-1:0] if_b;
  logic [6:0] if_p;
  logic rf_cnt_rst;
  logic if_cnt_rst;
  logic rf_off;
  logic if_off;

  assign rf_int = rf_feedback_divider[INT_LSB +: INT_W];
  assign rf_frac = rf_feedback_divider[FRAC_LSB +: FRAC_W];
  assign rf_den = rf_reference_divider[DEN_LSB +: FRAC_W];
  assign rf_r = rf_reference_divider[RFR_LSB +: RFR_W];
  assign rf_dbl = rf_reference_divider[DBL_BIT];
  assign if_r = if_reference_divider[IFR_LSB +: IFR_W];
  assign if_a = if_feedback_divider[A_LSB +: A_W];
  assign if_b = if_feedback_divider[B_LSB +: B_W];
  assign if_p = 7'h08 << if_feedback_divider[PRE_LSB +: 2];
  assign rf_cnt_rst = global_control[MST_CNT_RST] | rf_loop_control[CTL_CNT_RST];
  assign if_cnt_rst = global_control[MST_CNT_RST] | if_loop_control[CTL_CNT_RST];
  assign rf_off = global_control[MST_TRI] | global_control[MST_PD] | rf_loop_control[CTL_TRI]
    | rf_loop_control[CTL_PD];
  assign if_off = global_control[MST_TRI] | global_control[MST_PD] | if_loop_control[CTL_TRI]
    | if_loop_control[CTL_PD];

  // ----------------------------------------
  // Reference dividers
  // ----------------------------------------
  logic [4:0] rf_racc;
  logic [4:0] rf_rsum;
  logic rf_ref;
  logic [IFR_W-1:0] if_rcnt;
  logic if_ref;

  // Doubler adds two per cycle; R of 1 with doubler saturates at cycle rate
  assign rf_rsum = rf_racc + {3'b000, rf_dbl, ~rf_dbl};

  always_ff @(posedge ref_clk) begin
    if (rst || rf_cnt_rst || rf_r == '0) begin
      rf_racc <= 5'h00;
      rf_ref <= 1'b0;
    end else if (rf_rsum >= {1'b0, rf_r}) begin
      rf_racc <= rf_rsum - {1'b0, rf_r};
      rf_ref <= 1'b1;
    end else begin
      rf_racc <= rf_rsum;
      rf_ref <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || if_cnt_rst || if_r == '0) begin
      if_rcnt <= '0;
      if_ref <= 1'b0;
    end else if (if_rcnt + 15'h0001 >= if_r) begin
      if_rcnt <= '0;
      if_ref <= 1'b1;
    end else begin
      if_rcnt <= if_rcnt + 15'h0001;
      if_ref <= 1'b0;
    end
  end

  // ----------------------------------------
  // RF fractional feedback divider
  // ----------------------------------------
  logic [INT_W:0] rf_ncnt;
  logic [FRAC_W:0] rf_facc;
  logic [FRAC_W:0] rf_fsum;
  logic rf_carry;
  logic rf_fb;

  assign rf_fsum = rf_facc + {1'b0, rf_frac};

  always_ff @(posedge ref_clk) begin
    if (rst || rf_cnt_rst) begin
      rf_ncnt <= '0;
      rf_facc <= '0;
      rf_carry <= 1'b0;
      rf_fb <= 1'b0;
    end else if (rf_vco_tick && rf_ncnt + 9'h001 >= {1'b0, rf_int} + {8'h00, rf_carry}) begin
      rf_ncnt <= '0;
      rf_fb <= 1'b1;
      if (rf_fsum >= {1'b0, rf_den}) begin
        rf_facc <= rf_fsum - {1'b0, rf_den};
        rf_carry <= 1'b1;
      end else begin
        rf_facc <= rf_fsum;
        rf_carry <= 1'b0;
      end
    end else begin
      rf_ncnt <= rf_vco_tick ? rf_ncnt + 9'h001 : rf_ncnt;
      rf_fb <= 1'b0;
    end
  end

  // ----------------------------------------
  // IF pulse-swallow feedback divider
  // ----------------------------------------
  logic [6:0] pre_cnt;
  logic [A_W-1:0] a_cnt;
  logic [B_W-1:0] b_cnt;
  logic if_fb;
  logic pre_out;

  assign pre_out = if_vco_tick && pre_cnt + 7'h01 >= if_p + {6'h00, a_cnt != '0};

  always_ff @(posedge ref_clk) begin
    if (rst || if_cnt_rst) begin
      pre_cnt <= '0;
      a_cnt <= '0;
      b_cnt <= '0;
      if_fb <= 1'b0;
    end else if (pre_out) begin
      pre_cnt <= '0;
      if (b_cnt <= 12'h001) begin
        b_cnt <= if_b;
        a_cnt <= if_a;
        if_fb <= 1'b1;
      end else begin
        b_cnt <= b_cnt - 12'h001;
        a_cnt <= (a_cnt != '0) ? a_cnt - 6'h01 : a_cnt;
        if_fb <= 1'b0;
      end
    end else begin
      pre_cnt <= if_vco_tick ? pre_cnt + 7'h01 : pre_cnt;
      if_fb <= 1'b0;
    end
  end

  // ----------------------------------------
  // Phase detectors
  // ----------------------------------------
  logic rf_dlock;
  logic rf_alock;
  logic if_dlock;
  logic if_alock;

  dssc_pfd u_rf_pfd (
    .ref_clk(ref_clk), .rst(rst), .ref_pulse(rf_ref), .fb_pulse(rf_fb), .off(rf_off),
    .pump_up(rf_pump_up), .pump_dn(rf_pump_dn), .dlock(rf_dlock), .alock(rf_alock)
  );

  dssc_pfd u_if_pfd (
    .ref_clk(ref_clk), .rst(rst), .ref_pulse(if_ref), .fb_pulse(if_fb), .off(if_off),
    .pump_up(if_pump_up), .pump_dn(if_pump_dn), .dlock(if_dlock), .alock(if_alock)
  );

  // ----------------------------------------
  // Probe output multiplexer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.probe_out <= 1'b0;
      link.probe_oe <= 1'b0;
    end else begin
      unique case (global_control[MUX_LSB +: MUX_W])
        PROBE_RF_DLOCK: {link.probe_out, link.probe_oe} <= {rf_dlock, 1'b1};
        PROBE_RF_REF: {link.probe_out, link.probe_oe} <= {rf_ref, 1'b1};
        PROBE_RF_FB: {link.probe_out, link.probe_oe} <= {rf_fb, 1'b1};
        PROBE_RF_ALOCK: {link.probe_out, link.probe_oe} <= {1'b0, ~rf_alock};
        PROBE_IF_REF: {link.probe_out, link.probe_oe} <= {if_ref, 1'b1};
        PROBE_IF_FB: {link.probe_out, link.probe_oe} <= {if_fb, 1'b1};
        PROBE_IF_ALOCK: {link.probe_out, link.probe_oe} <= {1'b0, ~if_alock};
        PROBE_IF_DLOCK: {link.probe_out, link.probe_oe} <= {if_dlock, 1'b1};
        default: {link.probe_out, link.probe_oe} <= 2'b00;
      endcase
    end
  end
endmodule

/* inc/dssc_pkg.sv */
// Purpose: Shared constants for the dual synthesizer serial control ends
// Assumes: 50 MHz ref_clk, link clock made by the host
// Notes: Field positions count from the last bit shifted in
package dssc_pkg;
  localparam int CLK_NS = 20;
  localparam int SR_W = 24;
  // Latch address codes in the three lowest shifted bits
  localparam logic [2:0] ADDR_RF_N = 3'h0;
  localparam logic [2:0] ADDR_RF_R = 3'h1;
  localparam logic [2:0] ADDR_RF_CTL = 3'h2;
  localparam logic [2:0] ADDR_MASTER = 3'h3;
  localparam logic [2:0] ADDR_IF_N = 3'h4;
  localparam logic [2:0] ADDR_IF_R = 3'h5;
  localparam logic [2:0] ADDR_IF_CTL = 3'h6;
  // Latch widths
  localparam int RF_N_W = 24;
  localparam int RF_R_W = 21;
  localparam int RF_CTL_W = 16;
  localparam int MASTER_W = 11;
  localparam int IF_N_W = 24;
  localparam int IF_R_W = 19;
  localparam int IF_CTL_W = 16;
  // Field positions
  localparam int FRAC_LSB = 3;
  localparam int FRAC_W = 12;
  localparam int INT_LSB = 15;
  localparam int INT_W = 8;
  localparam int DEN_LSB = 3;
  localparam int RFR_LSB = 15;
  localparam int RFR_W = 4;
  localparam int DBL_BIT = 19;
  localparam int MST_CNT_RST = 3;
  localparam int MST_TRI = 4;
  localparam int MST_PD = 5;
  localparam int MUX_LSB = 7;
  localparam int MUX_W = 4;
  localparam int CTL_CNT_RST = 3;
  localparam int CTL_TRI = 4;
  localparam int CTL_PD = 5;
  localparam int A_LSB = 3;
  localparam int A_W = 6;
  localparam int B_LSB = 9;
  localparam int B_W = 12;
  localparam int PRE_LSB = 21;
  localparam int IFR_LSB = 3;
  localparam int IFR_W = 15;
  // Probe output select codes
  localparam logic [3:0] PROBE_OFF = 4'h0;
  localparam logic [3:0] PROBE_RF_DLOCK = 4'h1;
  localparam logic [3:0] PROBE_RF_REF = 4'h2;
  localparam logic [3:0] PROBE_RF_FB = 4'h3;
  localparam logic [3:0] PROBE_RF_ALOCK = 4'h4;
  localparam logic [3:0] PROBE_IF_REF = 4'h5;
  localparam logic [3:0] PROBE_IF_FB = 4'h6;
  localparam logic [3:0] PROBE_IF_ALOCK = 4'h7;
  localparam logic [3:0] PROBE_IF_DLOCK = 4'h8;
  // Timing
  localparam int ABL_NS = 40;
  localparam int ABL_CYC = (ABL_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_WIN_NS = 60;
  localparam int LOCK_WIN_CYC = LOCK_WIN_NS / CLK_NS;
  localparam int LOCK_COUNT = 5;
  localparam int SCLK_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_NS / 2 / CLK_NS;
  localparam int STROBE_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Host register map
  localparam logic [3:0] HOST_DATA = 4'h0;
  localparam logic [3:0] HOST_LEN = 4'h4;
  localparam logic [3:0] HOST_GO = 4'h8;
  localparam logic [3:0] HOST_STAT = 4'hC;
  localparam logic [4:0] HOST_LEN_RST = 5'h18;
endpackage

/* inc/dssc_if.sv */
// Purpose: Three-wire link plus probe pin between host and synthesizer
// Assumes: Probe pin has a pull-up when nobody drives it
// Notes: Probe driver enable is high while the device drives
interface dssc_if;
  logic ser_clk;
  logic ser_data;
  logic latch_strobe;
  logic probe_out;
  logic probe_oe;
  logic probe_line;
  assign probe_line = probe_oe ? probe_out : 1'b1;
  modport device (input ser_clk, input ser_data, input latch_strobe, output probe_out, output probe_oe);
  modport host (output ser_clk, output ser_data, output latch_strobe, input probe_line);
endinterface

/* verilog/dssc_host.sv */
// Purpose: Host end that shifts words out over the three-wire link
// Assumes: Software keeps divider values inside their legal ranges
// Notes: Link clock is made here by dividing ref_clk
module dssc_host
  import dssc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  dssc_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_STROBE = 2'b11
  } dssc_state_e;

  dssc_state_e state;
  logic [SR_W-1:0] word;
  logic [4:0] len;
  logic [SR_W-1:0] tx;
  logic [4:0] bits_left;
  logic [3:0] tick;
  logic [1:0] probe_sync;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word <= '0;
      len <= HOST_LEN_RST;
    end else if (wr && state == ST_IDLE) begin
      if (addr == HOST_DATA) begin
        word <= wdata[SR_W-1:0];
      end
      if (addr == HOST_LEN && wdata[4:0] != 5'h00 && wdata[4:0] <= HOST_LEN_RST) begin
        len <= wdata[4:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    probe_sync <= {probe_sync[0], link.probe_line};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        HOST_DATA: rdata <= {8'h00, word};
        HOST_LEN: rdata <= {27'h0, len};
        HOST_STAT: rdata <= {30'h0, probe_sync[1], state != ST_IDLE};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      tx <= '0;
      bits_left <= 5'h00;
      tick <= 4'h0;
      link.ser_clk <= 1'b0;
      link.ser_data <= 1'b0;
      link.latch_strobe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          link.latch_strobe <= 1'b0;
          if (wr && addr == HOST_GO && wdata[0]) begin
            tx <= word << (5'(SR_W) - len);
            bits_left <= len;
            tick <= 4'h0;
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          link.ser_clk <= 1'b0;
          link.ser_data <= tx[SR_W-1];
          tick <= tick + 4'h1;
          if (tick == 4'(SCLK_HALF_CYC - 1)) begin
            tick <= 4'h0;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          link.ser_clk <= 1'b1;
          tick <= tick + 4'h1;
          if (tick == 4'(SCLK_HALF_CYC - 1)) begin
            tick <= 4'h0;
            tx <= tx << 1;
            bits_left <= bits_left - 5'h01;
            state <= (bits_left == 5'h01) ? ST_STROBE : ST_LOW;
          end
        end
        ST_STROBE: begin
          link.ser_clk <= 1'b0;
          link.latch_strobe <= 1'b1;
          tick <= tick + 4'h1;
          if (tick == 4'(STROBE_CYC - 1)) begin
            tick <= 4'h0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* sim/dssc_chk.sv */
// Purpose: Concurrent checks on the three-wire link and probe pin
// Assumes: Link pins change only on ref_clk edges
// Notes: Watches the interface that joins host and device
module dssc_chk
  import dssc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic probe_out,
  input wire logic probe_oe,
  input wire logic probe_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] nbits;
  logic [7:0] since_stb;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) nbits <= 5'h0;
    else if ($rose(latch_strobe)) nbits <= 5'h0;
    else if ($rose(ser_clk)) nbits <= nbits + 5'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) since_stb <= 8'hFF;
    else if ($rose(latch_strobe)) since_stb <= 8'h0;
    else if (since_stb != 8'hFF) since_stb <= since_stb + 8'h1;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_data_setup;
    $rose(ser_clk) |-> ser_data == $past(ser_data) && ser_data == $past(ser_data, 2);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data moved before clock rise");
  property p_clk_high;
    $rose(ser_clk) |-> ser_clk [*4] ##1 !ser_clk;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high time wrong");
  property p_clk_low;
    $fell(ser_clk) |-> !ser_clk [*4];
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("link clock low time short");
  property p_data_hold;
    ser_clk |-> $stable(ser_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
  property p_stb_len;
    $rose(latch_strobe) |-> latch_strobe [*4] ##1 !latch_strobe;
  endproperty
  a_stb_len: assert property (p_stb_len) else $error("load strobe length wrong");
  property p_stb_clk_low;
    latch_strobe |-> !ser_clk;
  endproperty
  a_stb_clk_low: assert property (p_stb_clk_low) else $error("clock high during load strobe");
  property p_word_bits;
    $rose(latch_strobe) |-> nbits != 5'h0 && nbits <= 5'(SR_W);
  endproperty
  a_word_bits: assert property (p_word_bits) else $error("bit count before strobe wrong");
  property p_oe_follow;
    $changed(probe_oe) |-> since_stb >= 8'h2 && since_stb <= 8'hA;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("probe drive changed without a load");
endmodule

/* sim/tb_top.sv */
// Purpose: Self-checking bench, host and device joined by the link
// Assumes: Rates counted on the probe pin, one-cycle pulses
// Notes: Counts allow one pulse of phase slack
module tb_top
  import dssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata;
  logic rf_tick = 1'b0;
  logic if_tick = 1'b0;
  logic rf_up, rf_dn, if_up, if_dn;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 94475;
  logic [31:0] rq[$];
  logic [28:0] wq[$];
  logic [23:0] sh = 24'h0;
  int nb = 0;
  int run = 0;
  int ovl = 0;
  int maxrun = 0;
  int iovl = 0;

  dssc_if link();
  dssc_host u_dssc_host(.ref_clk(ref_clk), .rst(rst), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  dssc_device u_dssc_device(.ref_clk(ref_clk), .rst(rst), .link(link), .rf_vco_tick(rf_tick),
    .if_vco_tick(if_tick), .rf_pump_up(rf_up), .rf_pump_dn(rf_dn), .if_pump_up(if_up), .if_pump_dn(if_dn));
  dssc_chk u_dssc_chk(.ref_clk(ref_clk), .rst(rst), .ser_clk(link.ser_clk), .ser_data(link.ser_data),
    .latch_strobe(link.latch_strobe), .probe_out(link.probe_out), .probe_oe(link.probe_oe),
    .probe_line(link.probe_line));

  always #(CLK_NS / 2) ref_clk = ~ref_clk;

  // ----------------------------------------
  // Compare helpers and closing report
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Watchers: link words, read data, pumps
  // ----------------------------------------
  always @(posedge link.ser_clk) begin
    sh = {sh[22:0], link.ser_data};
    nb++;
  end

  always @(posedge link.latch_strobe) begin
    logic [28:0] e;
    if (wq.size() == 0) chk(32'h1, 32'h0);
    else begin
      e = wq.pop_front();
      chk({8'h0, sh & ((24'h1 << e[28:24]) - 24'h1)}, {8'h0, e[23:0]});
      chk(32'(nb), {27'h0, e[28:24]});
    end
    nb = 0;
  end

  always @(posedge ref_clk) begin
    rd_d <= rd;
    if (rd_d && rq.size() > 0) chk(rdata, rq.pop_front());
    if (rf_up === 1'b1 && rf_dn === 1'b1) begin
      run = run + 1;
      if (run == 1) ovl++;
      if (run > maxrun) maxrun = run;
    end else run = 0;
    if (if_up === 1'b1 && if_dn === 1'b1) iovl++;
  end

  // ----------------------------------------
  // Bus and link tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge ref_clk);
  endtask

  task automatic send(input logic [23:0] w, input logic [4:0] len);
    logic [31:0] v;
    int i;
    wr_reg(HOST_DATA, {8'h0, w});
    wr_reg(HOST_LEN, {27'h0, len});
    wr_reg(HOST_GO, 32'h1);
    wq.push_back({len, w & ((24'h1 << len) - 24'h1)});
    v = 32'h1;
    for (i = 0; i < 200 && v[0] === 1'b1; i++) rd_reg(HOST_STAT, v);
    if (v[0] !== 1'b0) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, v, 32'h0);
      tally_and_finish();
    end else repeat (8) @(posedge ref_clk);
  endtask

  function automatic logic [23:0] mst(input logic [3:0] m);
    return {13'h0, m, 4'h0, ADDR_MASTER};
  endfunction

  task automatic cnt_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (link.probe_line === 1'b1) c++;
    end
    @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [3:0] mc [5];
    int me [5];
    int c, r, d, i;
    mc = '{PROBE_RF_DLOCK, PROBE_RF_ALOCK, PROBE_IF_DLOCK, PROBE_OFF, 4'hF};
    me = '{0, 0, 0, 300, 300};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rq.push_back({27'h0, HOST_LEN_RST});
    rd_reg(HOST_LEN, v);
    rq.push_back(32'h0);
    rd_reg(4'h2, v);
    rq.push_back(32'h2);
    rd_reg(HOST_STAT, v);
    $display("test host_map done");
    send(mst(PROBE_RF_REF), 5'd24);
    for (i = 0; i < 3; i++) begin
      r = 1 + {$random(seed)} % 15;
      d = (r == 1) ? 0 : {$random(seed)} % 2;
      send({4'h0, d[0], r[3:0], 12'h002, ADDR_RF_R}, 5'd24);
      cnt_high(600, c);
      near(c, 600 * (1 + d) / r);
    end
    v = $random(seed);
    send({v[23:3], 3'h7}, 5'd24);
    send({1'b0, 8'd40, 12'h001, ADDR_RF_N}, 5'd24);
    cnt_high(600, c);
    near(c, 600 * (1 + d) / r);
    $display("test rf_reference done");
    send({6'h0, 15'd5, ADDR_IF_R}, 5'd24);
    send(mst(PROBE_IF_REF), 5'd24);
    cnt_high(600, c);
    near(c, 120);
    $display("test if_reference done");
    send({4'h0, 1'b0, 4'h4, 12'h002, ADDR_RF_R}, 5'd24);
    send({1'b0, 8'd31, 12'h001, ADDR_RF_N}, 5'd24);
    rf_tick <= 1'b1;
    send(mst(PROBE_RF_FB), 5'd24);
    ovl = 0;
    maxrun = 0;
    cnt_high(3150, c);
    near(c, 100);
    chk({31'h0, ovl > 0 && maxrun <= ABL_CYC}, 32'h1);
    $display("test rf_feedback done");
    send({1'b0, 2'h0, 12'd3, 6'd1, ADDR_IF_N}, 5'd24);
    if_tick <= 1'b1;
    send(mst(PROBE_IF_FB), 5'd24);
    iovl = 0;
    cnt_high(2500, c);
    near(c, 100);
    chk({31'h0, iovl > 0}, 32'h1);
    $display("test if_feedback done");
    rf_tick <= 1'b0;
    for (i = 0; i < 5; i++) begin
      send(mst(mc[i]), 5'd24);
      cnt_high(300, c);
      chk(32'(c), 32'(me[i]));
    end
    send(mst(PROBE_OFF) >> 4, 5'd20);
    $display("test probe_modes done");
    tally_and_finish();
  end
endmodule
